/* File: hw/csis_top.sv */
// Per-socket control: window enables, global and general control, IRQ steering.
// Assumes same-clock register port, window hit strobes and change events.
//
// Functional notes
// - One enable bit per window: I/O 1,0 at bits 7,6; memory 4..0 at 4..0.
// - Style bits select positive-edge ISA (0) or open-drain active-low PCI (1).
// - With explicit-ack select 0, reading the flag register clears pending changes.
// - With explicit-ack select 1, only writing 1 to a flag clears it.
// - Global bit 0 set enables chip power-down; clear means normal.
// - Voltage-sense pin levels read back as bits 7 and 6.
// - With clear-on-removal set, both card detects high reset configuration.
// - Soft reset bit 0 drives card reset high, 1 drives it low.
// - Kind bit 1 selects I/O card and enables the I/O multiplexer.
// - Change steering uses same coding; ignored while route-select and pci_csc_route_en are both set.
// - A steered change interrupt stays asserted until the flags are acknowledged (read, or write-back of 1s with explicit-ack).
module csis_top #(
  parameter logic SOCK_B = 1'b0
) (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [7:0]                   reg_wdata,
  output logic      [7:0]                   reg_rdata,
  output logic                              reg_rvalid,
  input  wire logic [csis_pkg::NUM_WIN-1:0] win_hit,
  output logic      [csis_pkg::NUM_WIN-1:0] win_fwd,
  input  wire logic [csis_pkg::FLAG_W-1:0]  card_status_change,
  input  wire logic                         pci_csc_route_en,
  input  wire logic                         card_irq_req,
  input  wire logic                         card_detect_a_n,
  input  wire logic                         card_detect_b_n,
  input  wire logic                         volt_sense_hi,
  input  wire logic                         volt_sense_lo,
  output logic      [csis_pkg::NUM_IRQ-1:0] host_irq_out,
  output logic      [csis_pkg::NUM_IRQ-1:0] host_irq_oe,
  output logic                              pci_int_n_out,
  output logic                              pci_int_n_oe,
  output logic                              card_reset_out,
  output logic                              io_card_mux_en,
  output logic                              chip_sleep,
  output logic                              config_cleared
);
  typedef struct packed {
    logic [7:0]                   win_en;
    logic [7:0]                   glb;
    logic [7:0]                   cdg;
    logic [7:0]                   igc;
    logic [7:0]                   scc;
    logic [csis_pkg::FLAG_W-1:0]  flags;
    logic [7:0]                   rdata;
    logic                         rvalid;
    logic [csis_pkg::NUM_WIN-1:0] fwd;
    logic [csis_pkg::NUM_IRQ-1:0] irq_out;
    logic [csis_pkg::NUM_IRQ-1:0] irq_oe;
    logic                         pci_out;
    logic                         pci_oe;
    logic                         card_rst;
    logic                         mux_en;
    logic                         sleep;
    logic                         cfg_clr;
  } csis_state_s;

  csis_state_s state_r;
  csis_state_s state_nxt;

  // Positions in the synchronised pin bundle
  localparam int PIN_IRQ   = 0;
  localparam int PIN_DET_A = 1;
  localparam int PIN_DET_B = 2;
  localparam int PIN_VS_LO = 3;
  localparam int PIN_VS_HI = 4;
  localparam int PIN_W     = 5;

  // Pin levels: card request, two detects, two voltage senses
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_sync;

  assign pins_raw = {volt_sense_hi, volt_sense_lo, card_detect_b_n, card_detect_a_n, card_irq_req};

  csis_sync #(
    .W (PIN_W)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     (pins_raw),
    .q     (pins_sync)
  );

  csis_steer_if card_steer ();
  csis_steer_if chg_steer ();

  assign card_steer.code = state_r.igc[csis_pkg::IGC_STEER_LO +: csis_pkg::STEER_W];
  assign chg_steer.code  = state_r.scc[csis_pkg::SCC_STEER_LO +: csis_pkg::STEER_W];

  csis_steer_dec u_card_dec (
    .s (card_steer.dec)
  );

  csis_steer_dec u_chg_dec (
    .s (chg_steer.dec)
  );

  logic [7:0]                   sock_step;
  logic                         hit_igc;
  logic                         hit_flags;
  logic                         hit_scc;
  logic                         hit_wen;
  logic                         hit_cdg;
  logic                         hit_glb;
  logic                         removed;
  logic                         card_style_pci;
  logic                         csc_style_pci;
  logic                         csc_pend;
  logic                         csc_to_pci;
  logic [csis_pkg::NUM_IRQ-1:0] card_sel;
  logic [csis_pkg::NUM_IRQ-1:0] csc_sel;
  logic [csis_pkg::NUM_IRQ-1:0] card_act;
  logic [csis_pkg::NUM_IRQ-1:0] csc_act;
  logic [csis_pkg::NUM_IRQ-1:0] isa_drive;
  logic [csis_pkg::FLAG_W-1:0]  flag_clr;
  logic                         wr_wen;
  logic                         wr_glb;
  logic                         wr_cdg;
  logic                         wr_igc;
  logic                         wr_scc;
  logic                         flag_rd_ack;
  logic                         flag_wr_ack;
  logic                         cfg_clear_now;
  logic [csis_pkg::FLAG_W-1:0]  flag_nxt;
  logic [csis_pkg::NUM_WIN-1:0] win_open;
  logic [csis_pkg::NUM_IRQ-1:0] line_out;
  logic [csis_pkg::NUM_IRQ-1:0] line_oe;
  logic [7:0]                   cdg_view;
  logic [7:0]                   rd_sel;

  assign sock_step = SOCK_B ? csis_pkg::SOCK_B_STEP : csis_pkg::RST_BYTE;
  assign hit_igc   = (reg_addr == 8'(csis_pkg::OFS_IGC + sock_step));
  assign hit_flags = (reg_addr == 8'(csis_pkg::OFS_FLAGS + sock_step));
  assign hit_scc   = (reg_addr == 8'(csis_pkg::OFS_SCC + sock_step));
  assign hit_wen   = (reg_addr == 8'(csis_pkg::OFS_WEN + sock_step));
  assign hit_cdg   = (reg_addr == 8'(csis_pkg::OFS_CDG + sock_step));
  assign hit_glb   = (reg_addr == 8'(csis_pkg::OFS_GLB + sock_step));

  assign wr_wen = reg_wr & hit_wen;
  assign wr_glb = reg_wr & hit_glb;
  assign wr_cdg = reg_wr & hit_cdg;
  assign wr_igc = reg_wr & hit_igc;
  assign wr_scc = reg_wr & hit_scc;

  // Detect pins are active low, so both high means the card is out
  assign removed       = pins_sync[PIN_DET_A] & pins_sync[PIN_DET_B];
  assign cfg_clear_now = state_r.cdg[csis_pkg::CDG_CFG_CLR] & removed;

  assign card_style_pci = SOCK_B ? state_r.glb[csis_pkg::GLB_B_STYLE] : state_r.glb[csis_pkg::GLB_A_STYLE];
  assign csc_style_pci  = state_r.glb[csis_pkg::GLB_CSC_STYLE];

  assign csc_pend   = |state_r.flags;
  assign csc_to_pci = state_r.igc[csis_pkg::IGC_PCI_ROUTE] & pci_csc_route_en;

  assign card_sel = card_steer.onehot;
  assign csc_sel  = csc_to_pci ? '0 : chg_steer.onehot;
  assign card_act = card_sel & {csis_pkg::NUM_IRQ{pins_sync[PIN_IRQ]}};
  assign csc_act  = csc_sel & {csis_pkg::NUM_IRQ{csc_pend}};

  // Totem-pole lines are driven whenever selected; open-drain only while asserting
  genvar g;
  generate
    for (g = 0; g < csis_pkg::NUM_IRQ; g++)
    begin : g_irq
      logic card_isa;
      logic csc_isa;
      logic card_od;
      logic csc_od;

      assign card_isa     = card_sel[g] & ~card_style_pci;
      assign csc_isa      = csc_sel[g] & ~csc_style_pci;
      assign card_od      = card_act[g] & card_style_pci;
      assign csc_od       = csc_act[g] & csc_style_pci;
      assign isa_drive[g] = card_isa | csc_isa;
      // Sharing a line with mixed styles ORs both sources
      assign line_out[g]  = isa_drive[g] & (card_act[g] | csc_act[g]);
      assign line_oe[g]   = isa_drive[g] | card_od | csc_od;
    end
  endgenerate

  // Flag clearing depends on the acknowledge method
  assign flag_rd_ack = hit_flags & reg_rd & ~state_r.glb[csis_pkg::GLB_XACK];
  assign flag_wr_ack = hit_flags & reg_wr & state_r.glb[csis_pkg::GLB_XACK];

  generate
    for (g = 0; g < csis_pkg::FLAG_W; g++)
    begin : g_flag
      assign flag_clr[g] = flag_rd_ack | (flag_wr_ack & reg_wdata[g]);
      // A new event wins over a clear in the same cycle
      assign flag_nxt[g] = (state_r.flags[g] & ~flag_clr[g]) | card_status_change[g];
    end
  endgenerate

  // Reserved enable position never opens a window
  generate
    for (g = 0; g < csis_pkg::NUM_WIN; g++)
    begin : g_win
      assign win_open[g] = state_r.win_en[g] & csis_pkg::WEN_MASK[g];
    end
  endgenerate

  // Sense bits show the synchronised pin levels, the rest the stored byte
  always_comb
  begin
    cdg_view                      = state_r.cdg;
    cdg_view[csis_pkg::CDG_VS_HI] = pins_sync[PIN_VS_HI];
    cdg_view[csis_pkg::CDG_VS_LO] = pins_sync[PIN_VS_LO];
  end

  // Byte that a read of the decoded address returns
  always_comb
  begin
    rd_sel = csis_pkg::RST_BYTE;
    unique case (1'b1)
      hit_wen:   rd_sel = state_r.win_en;
      hit_glb:   rd_sel = state_r.glb;
      hit_igc:   rd_sel = state_r.igc;
      hit_scc:   rd_sel = state_r.scc;
      hit_flags: rd_sel = 8'(state_r.flags);
      hit_cdg:   rd_sel = cdg_view;
      default:   rd_sel = csis_pkg::RST_BYTE;
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;

    // Register writes
    if (wr_wen)
      state_nxt.win_en = reg_wdata & csis_pkg::WEN_MASK;
    if (wr_glb)
      state_nxt.glb = reg_wdata;
    if (wr_cdg)
      state_nxt.cdg = reg_wdata & csis_pkg::CDG_WMASK;
    if (wr_igc)
      state_nxt.igc = reg_wdata;
    if (wr_scc)
      state_nxt.scc = reg_wdata;

    // Flags after acknowledge and new events
    state_nxt.flags = flag_nxt;

    // With clear-on-removal set, removal clears the slot configuration
    state_nxt.cfg_clr = 1'b0;
    if (cfg_clear_now)
    begin
      state_nxt.win_en  = csis_pkg::RST_BYTE;
      state_nxt.igc     = csis_pkg::RST_BYTE;
      state_nxt.scc     = csis_pkg::RST_BYTE;
      state_nxt.cfg_clr = 1'b1;
    end

    // Read data, one cycle after the strobe
    state_nxt.rvalid = reg_rd;
    state_nxt.rdata  = reg_rd ? rd_sel : csis_pkg::RST_BYTE;

    // Window forwarding
    state_nxt.fwd = win_hit & win_open;

    // Host IRQ pins
    state_nxt.irq_out = line_out;
    state_nxt.irq_oe  = line_oe;
    state_nxt.pci_out = 1'b0;
    state_nxt.pci_oe  = csc_to_pci & csc_pend;

    // General and global control outputs
    state_nxt.card_rst = ~state_r.igc[csis_pkg::IGC_SOFT_RST];
    state_nxt.mux_en   = state_r.igc[csis_pkg::IGC_KIND];
    state_nxt.sleep    = state_r.glb[csis_pkg::GLB_SLEEP];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_r          <= '0;
      state_r.card_rst <= 1'b1;
    end
    else
      state_r <= state_nxt;
  end

  assign reg_rdata      = state_r.rdata;
  assign reg_rvalid     = state_r.rvalid;
  assign win_fwd        = state_r.fwd;
  assign host_irq_out   = state_r.irq_out;
  assign host_irq_oe    = state_r.irq_oe;
  assign pci_int_n_out  = state_r.pci_out;
  assign pci_int_n_oe   = state_r.pci_oe;
  assign card_reset_out = state_r.card_rst;
  assign io_card_mux_en = state_r.mux_en;
  assign chip_sleep     = state_r.sleep;
  assign config_cleared = state_r.cfg_clr;
endmodule

/* File: hw/csis_pkg.sv */
// Constants for the socket interrupt steering and control block.
// Assumes an 8-bit register port addressed by the socket A byte offsets.
package csis_pkg;
  // Register byte offsets for socket A; socket B sits one step higher
  localparam logic [7:0] OFS_IGC     = 8'h83;
  localparam logic [7:0] OFS_FLAGS   = 8'h84;
  localparam logic [7:0] OFS_SCC     = 8'h85;
  localparam logic [7:0] OFS_WEN     = 8'h86;
  localparam logic [7:0] OFS_CDG     = 8'h96;
  localparam logic [7:0] OFS_GLB     = 8'h9e;
  localparam logic [7:0] SOCK_B_STEP = 8'h40;

  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] WEN_MASK  = 8'hdf;
  localparam logic [7:0] CDG_WMASK = 8'h3f;

  // Global control fields
  localparam int GLB_B_STYLE   = 4;
  localparam int GLB_A_STYLE   = 3;
  localparam int GLB_XACK      = 2;
  localparam int GLB_CSC_STYLE = 1;
  localparam int GLB_SLEEP     = 0;

  // Card detect and general control fields
  localparam int CDG_VS_HI   = 7;
  localparam int CDG_VS_LO   = 6;
  localparam int CDG_CFG_CLR = 1;

  // Interrupt and general control fields
  localparam int IGC_SOFT_RST  = 6;
  localparam int IGC_KIND      = 5;
  localparam int IGC_PCI_ROUTE = 4;
  localparam int IGC_STEER_LO  = 0;
  localparam int SCC_STEER_LO  = 4;

  localparam int STEER_W = 4;
  localparam int NUM_IRQ = 16;
  localparam int FLAG_W  = 4;
  localparam int NUM_WIN = 8;

  // Host IRQ numbers that a steering code may select
  localparam logic [NUM_IRQ-1:0] IRQ_VALID = 16'hdeb8;
endpackage

/* File: hw/csis_steer_if.sv */
// Steering code and the decoded one-hot host IRQ select.
// Assumes one decoder per steering field.
interface csis_steer_if;
  logic [csis_pkg::STEER_W-1:0] code;
  logic [csis_pkg::NUM_IRQ-1:0] onehot;
  modport src (output code, input onehot);
  modport dec (input code, output onehot);
endinterface

/* File: hw/csis_steer_dec.sv */
// Decoder from a 4-bit steering code to a one-hot host IRQ select.
// Assumes the code comes from a register on the same clock.
module csis_steer_dec (
  csis_steer_if.dec s
);
  genvar i;
  generate
    for (i = 0; i < csis_pkg::NUM_IRQ; i++)
    begin : g_line
      // Code equals IRQ number; zero and reserved codes select nothing
      assign s.onehot[i] = (s.code == csis_pkg::STEER_W'(i)) && csis_pkg::IRQ_VALID[i];
    end
  endgenerate
endmodule

/* File: hw/csis_sync.sv */
// Two-flop synchroniser for a vector of pin levels.
// Assumes each bit is an independent slow level.
module csis_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } csis_sync_s;

  csis_sync_s state_r;
  csis_sync_s state_nxt;

  always_comb
  begin
    state_nxt    = state_r;
    state_nxt.s1 = d;
    state_nxt.s2 = state_r.s1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign q = state_r.s2;
endmodule

/* File: bench/csis_checker.sv */
// Assertions on the register port and control outputs of csis_top.
// Assumes it is bound into csis_top built with socket A offsets.
module csis_checker (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic [7:0] win_hit,
  input wire logic [7:0] win_fwd,
  input wire logic       pci_int_n_out,
  input wire logic       pci_int_n_oe,
  input wire logic       card_reset_out,
  input wire logic       io_card_mux_en,
  input wire logic       chip_sleep,
  input wire logic       config_cleared
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence igc_wr;
    reg_wr && reg_addr == 8'h83;
  endsequence
  sequence glb_wr;
    reg_wr && reg_addr == 8'h9e;
  endsequence
  sequence wen_wr;
    reg_wr && reg_addr == 8'h86;
  endsequence
  // Writes land in the register one cycle on, at the output one more
  soft_reset_a: assert property (igc_wr |=> ##1 card_reset_out == !$past(reg_wdata[6], 2))
    else $error("card reset level wrong");
  kind_mux_a: assert property (igc_wr |=> ##1 io_card_mux_en == $past(reg_wdata[5], 2))
    else $error("io mux enable wrong");
  sleep_bit_a: assert property (glb_wr |=> ##1 chip_sleep == $past(reg_wdata[0], 2))
    else $error("sleep level wrong");
  wen_apply_a: assert property (wen_wr |=> ##1 win_fwd == ($past(reg_wdata, 2) & $past(win_hit) & 8'hdf))
    else $error("window enable not applied");
  fwd_gate_a: assert property ((win_fwd & ~$past(win_hit)) == 8'h00)
    else $error("forward without hit");
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rd_quiet_a: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
    else $error("read data without read");
  pci_low_a: assert property (pci_int_n_oe |-> !pci_int_n_out)
    else $error("pci line driven high");
  clear_win_a: assert property (config_cleared [*3] |-> win_fwd == 8'h00)
    else $error("windows open after removal clear");
endmodule

/* File: bench/csis_socket_model.sv */
// Card socket model: detect, voltage-sense and interrupt pins of one card.
// Assumes the bench sets insertion, request and sense levels.
module csis_socket_model (
  input  wire logic       clock,
  input  wire logic       present,
  input  wire logic       want_irq,
  input  wire logic [1:0] vs,
  input  wire logic       card_reset_out,
  output logic            card_irq_req,
  output logic            card_detect_a_n,
  output logic            card_detect_b_n,
  output logic            volt_sense_hi,
  output logic            volt_sense_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;
  always @(posedge clock)
    flip <= !flip;
  // A card in reset stays quiet; request and sense pins of an absent card float
  assign card_irq_req = present ? want_irq & ~card_reset_out : flip;
  assign card_detect_a_n = !present;
  assign card_detect_b_n = !present;
  assign {volt_sense_hi, volt_sense_lo} = present ? vs : {flip, !flip};
endmodule

/* File: bench/tb.sv */
// Self-checking bench for csis_top with a card socket model.
// Assumes socket A offsets and a 125 MHz clock.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  win_hit = 8'h00;
  logic [3:0]  card_status_change = 4'h0;
  logic        pci_csc_route_en = 1'b0;
  logic        present = 1'b1;
  logic        want_irq = 1'b0;
  logic [1:0]  vs = 2'h0;
  logic [31:0] seed = 32'h6241;
  logic [7:0]  en;
  logic [7:0]  ra[6] = '{8'h83, 8'h85, 8'h86, 8'h96, 8'h9e, 8'h90};
  logic [7:0]  reg_rdata, win_fwd;
  logic [15:0] host_irq_out, host_irq_oe;
  logic        reg_rvalid, pci_int_n_out, pci_int_n_oe, card_reset_out;
  logic        io_card_mux_en, chip_sleep, config_cleared, card_irq_req;
  logic        card_detect_a_n, card_detect_b_n, volt_sense_hi, volt_sense_lo;
  int          n_fail = 0;
  int          n_checks = 0;
  csis_top u_csis_top (
    .clock, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .win_hit, .win_fwd, .card_status_change, .pci_csc_route_en, .card_irq_req,
    .card_detect_a_n, .card_detect_b_n, .volt_sense_hi, .volt_sense_lo, .host_irq_out,
    .host_irq_oe, .pci_int_n_out, .pci_int_n_oe, .card_reset_out, .io_card_mux_en,
    .chip_sleep, .config_cleared
  );
  csis_socket_model u_csis_socket_model (
    .clock, .present, .want_irq, .vs, .card_reset_out, .card_irq_req,
    .card_detect_a_n, .card_detect_b_n, .volt_sense_hi, .volt_sense_lo
  );
  always #4 clock = ~clock;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] sel(input logic [3:0] c);
    return c inside {4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf} ? 16'h0001 << c : 16'h0000;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk("rvalid", 16'h0001, 16'(reg_rvalid));
    chk("rdata", 16'(e), 16'(reg_rdata));
  endtask
  // Covers the pin synchronisers plus state and output flops
  task automatic settle();
    repeat (6) @(negedge clock);
  endtask
  task automatic flag(input logic [3:0] f);
    @(negedge clock);
    card_status_change = f;
    @(negedge clock);
    card_status_change = 4'h0;
    settle();
  endtask
  task automatic end_sim();
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    chk("crst", 16'h0001, 16'(card_reset_out));
    foreach (ra[i]) rd(ra[i], 8'h00);
    repeat (8)
    begin
      en = 8'(rnd());
      win_hit = 8'(rnd());
      wr(8'h86, en);
      settle();
      chk("fwd", 16'(win_hit & en & 8'hdf), 16'(win_fwd));
      rd(8'h86, en & 8'hdf);
    end
    for (int i = 1; i >= 0; i--)
    begin
      wr(8'h9e, 8'(i));
      settle();
      chk("sleep", 16'(i), 16'(chip_sleep));
    end
    wr(8'h83, 8'h60);
    want_irq = 1'b1;
    settle();
    chk("crst", 16'h0000, 16'(card_reset_out));
    chk("mux", 16'h0001, 16'(io_card_mux_en));
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h83, 8'h60 | 8'(i));
      wr(8'h9e, 8'h00);
      settle();
      chk("isa_oe", sel(4'(i)), host_irq_oe);
      chk("isa_out", sel(4'(i)), host_irq_out);
      wr(8'h9e, 8'h08);
      settle();
      chk("pci_oe", sel(4'(i)), host_irq_oe);
      chk("pci_out", 16'h0000, host_irq_out);
    end
    want_irq = 1'b0;
    settle();
    chk("pci_idle", 16'h0000, host_irq_oe);
    wr(8'h83, 8'h40);
    wr(8'h9e, 8'h00);
    wr(8'h85, 8'h50);
    en = 8'(rnd()) & 8'h0f | 8'h01;
    flag(en[3:0]);
    settle();
    chk("csc_hold", 16'h0020, host_irq_out);
    rd(8'h84, en);
    settle();
    chk("csc_ack", 16'h0000, host_irq_out);
    wr(8'h9e, 8'h04);
    flag(4'h6);
    rd(8'h84, 8'h06);
    settle();
    chk("csc_rd", 16'h0020, host_irq_out);
    wr(8'h84, 8'h02);
    rd(8'h84, 8'h04);
    wr(8'h84, 8'h04);
    settle();
    chk("csc_wb", 16'h0000, host_irq_out);
    pci_csc_route_en = 1'b1;
    wr(8'h83, 8'h50);
    flag(4'h1);
    chk("pci_csc", 16'h0001, 16'(pci_int_n_oe));
    chk("csc_line", 16'h0000, host_irq_oe);
    wr(8'h84, 8'h01);
    settle();
    chk("pci_csc", 16'h0000, 16'(pci_int_n_oe));
    pci_csc_route_en = 1'b0;
    wr(8'h9e, 8'h06);
    flag(4'h1);
    chk("csc_od_oe", 16'h0020, host_irq_oe);
    chk("csc_od_out", 16'h0000, host_irq_out);
    chk("pci_off", 16'h0000, 16'(pci_int_n_oe));
    wr(8'h84, 8'h01);
    settle();
    chk("csc_od_idle", 16'h0000, host_irq_oe);
    repeat (4)
    begin
      vs = 2'(rnd());
      settle();
      rd(8'h96, {vs, 6'h00});
    end
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h96, 8'(2 * i));
      wr(8'h86, 8'hff);
      present = 1'b0;
      settle();
      chk("cleared", 16'(i), 16'(config_cleared));
      rd(8'h86, (i != 0) ? 8'h00 : 8'hdf);
      present = 1'b1;
      settle();
    end
    chk("crst", 16'h0001, 16'(card_reset_out));
    end_sim();
  end
endmodule
bind csis_top csis_checker u_csis_checker (
  .clock, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
  .win_hit, .win_fwd, .pci_int_n_out, .pci_int_n_oe, .card_reset_out,
  .io_card_mux_en, .chip_sleep, .config_cleared
);
